// ### core/slc_link_check.sv
// Purpose: checks 12-bit word link settings, picks the pll range, paces out
// Assumes: APB master on sys_clk_i, sample sink on the same clock
// Notes: results lag a configuration write by one cycle
`include "slc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - output sample rate is the converter clock over the decimation ratio.
// - only frames times octets that divide by four are accepted.
// - each lane, converter and octet set accepts only listed decimations.
// - each sample word is 12 bits, data plus up to 3 control bits.
// - lanes, converters, octets and samples per frame fix the framing.
module slc_link_check
  import slc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [11:0] sample_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  output logic link_en_o,
  output logic cfg_ok_o,
  output logic [7:0] pll_range_o
);

  // ========================================================
  // state and buffer
  slc_state_type s_r;
  slc_state_type s_nxt;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [11:0] fifo_out_data;
  logic [27:0] num_c;
  logic [27:0] den_c;
  logic [11:0] kf_c;
  logic [1:0] band_c;
  logic [6:0] dcm_bit_c;
  logic acc_c;
  logic [`SLC_ADDR_W-1:0] adr_c;
  logic mapped_c;
  logic cfg_wr_c;

  slc_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pwdata_i[`SLC_DATA_F]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // ========================================================
  // allowed decimations per lane set and rate band
  function automatic logic [6:0] dcm_mask(input logic [2:0] l,
      input logic [3:0] m, input logic [3:0] f, input logic [1:0] b);
    case ({l, m, f, b})
      {3'h1, 4'h1, 4'h3, 2'h0}: dcm_mask = 7'h04;
      {3'h3, 4'h1, 4'h1, 2'h0}: dcm_mask = 7'h01;
      {3'h1, 4'h2, 4'h3, 2'h0}: dcm_mask = 7'h24;
      {3'h1, 4'h2, 4'h3, 2'h1}: dcm_mask = 7'h04;
      {3'h2, 4'h2, 4'h3, 2'h0}: dcm_mask = 7'h04;
      {3'h3, 4'h2, 4'h1, 2'h0}: dcm_mask = 7'h07;
      {3'h3, 4'h2, 4'h1, 2'h1}: dcm_mask = 7'h01;
      {3'h1, 4'h4, 4'h6, 2'h0}: dcm_mask = 7'h60;
      {3'h1, 4'h4, 4'h6, 2'h1}: dcm_mask = 7'h24;
      {3'h1, 4'h4, 4'h6, 2'h2}: dcm_mask = 7'h04;
      {3'h2, 4'h4, 4'h3, 2'h0}: dcm_mask = 7'h24;
      {3'h2, 4'h4, 4'h3, 2'h1}: dcm_mask = 7'h04;
      {3'h3, 4'h4, 4'h2, 2'h0}: dcm_mask = 7'h3A;
      {3'h3, 4'h4, 4'h2, 2'h1}: dcm_mask = 7'h07;
      {3'h3, 4'h4, 4'h2, 2'h2}: dcm_mask = 7'h01;
      {3'h4, 4'h4, 4'h3, 2'h0}: dcm_mask = 7'h04;
      {3'h2, 4'h8, 4'h6, 2'h0}: dcm_mask = 7'h60;
      {3'h2, 4'h8, 4'h6, 2'h1}: dcm_mask = 7'h20;
      {3'h4, 4'h8, 4'h3, 2'h0}: dcm_mask = 7'h20;
      default: dcm_mask = 7'h00;
    endcase
  endfunction

  // ========================================================
  // rate arithmetic, kept as products to avoid a divider
  // rate times lanes times ratio
  assign num_c = 28'(s_r.conv) * `SLC_WORD_X_ENC * 28'(s_r.adc_mhz);
  assign den_c = 28'(s_r.lanes) * 28'(s_r.chip_decimation_ratio);
  assign kf_c = 12'(s_r.frames) * 12'(s_r.octets);
  assign acc_c = psel_i && penable_i;
  assign adr_c = paddr_i[`SLC_ADDR_W-1:0];
  assign mapped_c = (paddr_i[31:`SLC_ADDR_W] == '0) &&
      (adr_c <= `SLC_OFS_DATA) && (adr_c[1:0] == 2'b00);
  assign cfg_wr_c = acc_c && pwrite_i && (s_r.ph == SLC_DONE) &&
      (adr_c == `SLC_OFS_LINK || adr_c == `SLC_OFS_DECIM ||
       adr_c == `SLC_OFS_ADCCLK);
  // data write only completes with room, so the push never drops
  assign fifo_in_valid = acc_c && pwrite_i && (s_r.ph == SLC_DONE) &&
      (adr_c == `SLC_OFS_DATA);
  assign fifo_out_ready = s_r.link_en && s_r.cfg_ok &&
      (s_r.pace == 4'h0) && (!s_r.smp_v || sample_ready_i);

  always_comb begin
    case (s_r.chip_decimation_ratio)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: dcm_bit_c = 7'(1) << (s_r.chip_decimation_ratio - 1);
      4'hC: dcm_bit_c = 7'h40;
      default: dcm_bit_c = 7'h00;
    endcase
    if (num_c > `SLC_BAND3_LO * den_c) begin
      band_c = 2'h3;
    end else if (num_c >= `SLC_BAND2_LO * den_c) begin
      band_c = 2'h2;
    end else if (num_c >= `SLC_BAND1_LO * den_c) begin
      band_c = 2'h1;
    end else begin
      band_c = 2'h0;
    end
  end

  // ========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rate_err = (den_c == '0) ||
        ({num_c[26:0], 1'b0} < `SLC_RATE_MIN_X2 * den_c) ||
        (num_c > `SLC_RATE_MAX * den_c);
    s_nxt.kf_err = (kf_c[1:0] != 2'b00) || (s_r.frames < `SLC_K_MIN) ||
        (s_r.frames > `SLC_K_MAX) ||
        (s_r.octets == 4'h1 && s_r.frames < `SLC_K_MIN_F1) ||
        (s_r.octets == 4'h2 && s_r.frames < `SLC_K_MIN_F2) ||
        (s_r.octets == 4'h4 && s_r.frames < `SLC_K_MIN_F4);
    // pairing of link set and decimation
    s_nxt.dcm_err = (dcm_mask(s_r.lanes, s_r.conv, s_r.octets, band_c) &
        dcm_bit_c) == 7'h00;
    // bits per frame match on both sides
    s_nxt.frame_err = (12'(s_r.conv) * 12'(s_r.spf) * `SLC_WORD_BITS) !=
        (12'(s_r.octets) * `SLC_OCTET_BITS * 12'(s_r.lanes));
    s_nxt.cfg_ok = !(s_nxt.rate_err || s_nxt.kf_err || s_nxt.dcm_err ||
        s_nxt.frame_err);
    case (band_c)
      2'h3: s_nxt.pll = `SLC_PLL_BAND3;
      2'h2: s_nxt.pll = `SLC_PLL_BAND2;
      2'h1: s_nxt.pll = `SLC_PLL_BAND1;
      default: s_nxt.pll = `SLC_PLL_BAND0;
    endcase
    // bus: one wait state, more for a data write while the buffer is full; write lands on the completing edge
    case (s_r.ph)
      SLC_IDLE: begin
        if (acc_c && !(pwrite_i && adr_c == `SLC_OFS_DATA &&
            !fifo_in_ready)) begin
          s_nxt.ph = SLC_DONE;
          s_nxt.pready = 1'b1;
          s_nxt.pslverr = !mapped_c;
          s_nxt.prdata = '0;
          if (!pwrite_i && mapped_c) begin
            case (adr_c)
              `SLC_OFS_CTRL: s_nxt.prdata[`SLC_CTRL_EN] = s_r.link_en;
              `SLC_OFS_LINK: s_nxt.prdata[`SLC_LINK_ALL] = {s_r.cs, s_r.spf,
                  s_r.frames, s_r.octets, s_r.conv, s_r.lanes};
              `SLC_OFS_DECIM: s_nxt.prdata[`SLC_DECIM_F] = s_r.chip_decimation_ratio;
              `SLC_OFS_ADCCLK: s_nxt.prdata[`SLC_ADCCLK_F] = s_r.adc_mhz;
              `SLC_OFS_STATUS: s_nxt.prdata[`SLC_ST_ALL] = {s_r.pll, 2'b00,
                  s_r.refused, s_r.frame_err, s_r.dcm_err, s_r.kf_err,
                  s_r.rate_err, s_r.cfg_ok};
              default: s_nxt.prdata = '0;
            endcase
          end
        end
      end
      SLC_DONE: begin
        s_nxt.ph = SLC_IDLE;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (acc_c && pwrite_i && mapped_c) begin
          case (adr_c)
            `SLC_OFS_CTRL: s_nxt.link_en = pwdata_i[`SLC_CTRL_EN];
            `SLC_OFS_STATUS: begin
              if (pwdata_i[`SLC_ST_REFUSED]) begin
                s_nxt.refused = 1'b0;
              end
            end
            default: ;
          endcase
        end
        if (cfg_wr_c && s_r.link_en) begin
          s_nxt.refused = 1'b1;
        end else if (cfg_wr_c) begin
          case (adr_c)
            `SLC_OFS_LINK: {s_nxt.cs, s_nxt.spf, s_nxt.frames,
                s_nxt.octets, s_nxt.conv, s_nxt.lanes} = pwdata_i[`SLC_LINK_ALL];
            `SLC_OFS_DECIM: s_nxt.chip_decimation_ratio = pwdata_i[`SLC_DECIM_F];
            default: s_nxt.adc_mhz = pwdata_i[`SLC_ADCCLK_F];
          endcase
        end
      end
      default: s_nxt.ph = SLC_IDLE;
    endcase
    // pace samples at the output rate
    if (s_r.pace != 4'h0) begin
      s_nxt.pace = s_r.pace - 4'h1;
    end else if (fifo_out_valid && fifo_out_ready) begin
      s_nxt.pace = s_r.chip_decimation_ratio - 4'h1;
    end
    if (s_r.smp_v && sample_ready_i) begin
      s_nxt.smp_v = 1'b0;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      s_nxt.smp_v = 1'b1;
      s_nxt.smp = fifo_out_data;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign sample_o = s_r.smp;
  assign sample_valid_o = s_r.smp_v;
  assign link_en_o = s_r.link_en;
  assign cfg_ok_o = s_r.cfg_ok;
  assign pll_range_o = s_r.pll;

  // ========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_rate_over_max: assert property (
    (num_c > `SLC_RATE_MAX * den_c) |=> s_r.rate_err && !cfg_ok_o)
    else $error("lane rate over maximum not flagged");
  a_pll_top_band: assert property (
    (num_c > `SLC_BAND3_LO * den_c) |=> pll_range_o == `SLC_PLL_BAND3)
    else $error("wrong pll code in top band");
  a_pll_upper_mid: assert property (
    (num_c >= `SLC_BAND2_LO * den_c && num_c <= `SLC_BAND3_LO * den_c)
    |=> pll_range_o == `SLC_PLL_BAND2)
    else $error("wrong pll code in upper middle band");
  a_pll_lower_mid: assert property (
    (num_c >= `SLC_BAND1_LO * den_c && num_c < `SLC_BAND2_LO * den_c)
    |=> pll_range_o == `SLC_PLL_BAND1)
    else $error("wrong pll code in lower middle band");
  a_pll_bottom: assert property (
    (num_c < `SLC_BAND1_LO * den_c) |=> pll_range_o == `SLC_PLL_BAND0)
    else $error("wrong pll code in bottom band");
  a_kf_multiple: assert property (
    (kf_c[1:0] != 2'b00) |=> s_r.kf_err)
    else $error("multiframe size not multiple of four accepted");
  a_dcm_pairing: assert property (
    (s_r.lanes == 3'h1 && s_r.conv == 4'h1 && s_r.octets == 4'h3 &&
     s_r.chip_decimation_ratio == 4'h1) |=> s_r.dcm_err)
    else $error("unsupported decimation pairing accepted");
  a_error_blocks: assert property (
    (s_r.rate_err || s_r.kf_err || s_r.dcm_err || s_r.frame_err)
    |-> !cfg_ok_o && !fifo_out_ready)
    else $error("link runs with a configuration error");
  a_locked_refuse: assert property (
    (cfg_wr_c && link_en_o) |=> s_r.refused && $stable(s_r.chip_decimation_ratio) &&
    $stable(s_r.adc_mhz) && $stable(s_r.frames))
    else $error("configuration changed while link up");
  a_pace_gap: assert property (
    (fifo_out_valid && fifo_out_ready && s_r.chip_decimation_ratio > 4'h1)
    |=> !fifo_out_ready ##0 s_r.pace == $past(s_r.chip_decimation_ratio) - 4'h1)
    else $error("samples leave faster than the output rate");

  c_sample_out: cover property (sample_valid_o && sample_ready_i);
  c_cfg_ok: cover property ($rose(cfg_ok_o));
  c_refused: cover property ($rose(s_r.refused));
  c_top_band: cover property (pll_range_o == `SLC_PLL_BAND3 && cfg_ok_o);
endmodule // slc_link_check
`default_nettype wire

// ### core/slc_defines.svh
// Purpose: register map, field positions and limits of the link checker
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: rates are held in Mbps, the converter clock in MHz
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH

// ==========================================================
// register offsets
`define SLC_ADDR_W 8
`define SLC_OFS_CTRL 8'h00
`define SLC_OFS_LINK 8'h04
`define SLC_OFS_DECIM 8'h08
`define SLC_OFS_ADCCLK 8'h0C
`define SLC_OFS_STATUS 8'h10
`define SLC_OFS_DATA 8'h14

// ==========================================================
// field positions
`define SLC_CTRL_EN 0
`define SLC_LINK_L 2:0
`define SLC_LINK_M 6:3
`define SLC_LINK_F 10:7
`define SLC_LINK_K 16:11
`define SLC_LINK_S 20:17
`define SLC_LINK_CS 22:21
`define SLC_LINK_ALL 22:0
`define SLC_ST_ALL 15:0
`define SLC_DECIM_F 3:0
`define SLC_ADCCLK_F 15:0
`define SLC_DATA_F 11:0
`define SLC_ST_REFUSED 5

// ==========================================================
// rate limits, scaled to 28 bits
`define SLC_RATE_MIN_X2 28'h000_0D2F
`define SLC_RATE_MAX 28'h000_3E80
`define SLC_BAND3_LO 28'h000_34BC
`define SLC_BAND2_LO 28'h000_1A5E
`define SLC_BAND1_LO 28'h000_0D2F
`define SLC_WORD_X_ENC 28'h000_000F
`define SLC_WORD_BITS 12'h00C
`define SLC_OCTET_BITS 12'h008

// ==========================================================
// serializer pll range codes
`define SLC_PLL_BAND3 8'h30
`define SLC_PLL_BAND2 8'h00
`define SLC_PLL_BAND1 8'h10
`define SLC_PLL_BAND0 8'h50

// ==========================================================
// multiframe limits
`define SLC_K_MIN 6'h04
`define SLC_K_MAX 6'h20
`define SLC_K_MIN_F1 6'h14
`define SLC_K_MIN_F2 6'h0C
`define SLC_K_MIN_F4 6'h08

`endif

// ### core/slc_pkg.sv
// Purpose: types shared by the link checker
// Assumes: slc_defines.svh gives the numbers
// Notes: all state of the top is one struct
package slc_pkg;

  typedef enum logic [1:0] {
    SLC_IDLE = 2'b00,
    SLC_DONE = 2'b01
  } slc_apb_type;

  typedef struct packed {
    slc_apb_type ph;
    logic link_en;
    logic [2:0] lanes;
    logic [3:0] conv;
    logic [3:0] octets;
    logic [5:0] frames;
    logic [3:0] spf;
    logic [1:0] cs;
    logic [3:0] chip_decimation_ratio;
    logic [15:0] adc_mhz;
    logic refused;
    logic rate_err;
    logic kf_err;
    logic dcm_err;
    logic frame_err;
    logic cfg_ok;
    logic [7:0] pll;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pace;
    logic [11:0] smp;
    logic smp_v;
  } slc_state_type;

endpackage

// ### core/slc_fifo.sv
// Purpose: sample buffer between the register bus and the lane output
// Assumes: one clock, both sides on it
// Notes: in_ready_o falls when full and stalls the bus write
`timescale 1ns/10ps
`default_nettype none
module slc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } slc_fifo_type;

  slc_fifo_type f_r;
  slc_fifo_type f_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (f_r.count != (PW+1)'(DEPTH));
  assign out_valid_o = (f_r.count != '0);
  assign out_data_o = f_r.mem[f_r.rptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    f_nxt = f_r;
    if (push) begin
      f_nxt.mem[f_r.wptr] = in_data_i;
      f_nxt.wptr = (f_r.wptr == PW'(DEPTH-1)) ? '0 : f_r.wptr + 1'b1;
    end
    if (pop) begin
      f_nxt.rptr = (f_r.rptr == PW'(DEPTH-1)) ? '0 : f_r.rptr + 1'b1;
    end
    f_nxt.count = f_r.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_fifo_no_overrun: assert property (
    !in_ready_o |=> f_r.count == $past(f_r.count) - (PW+1)'($past(pop)))
    else $error("fifo count moved while full");
  c_fifo_full: cover property (!in_ready_o);
endmodule // slc_fifo
`default_nettype wire

// ### tb/slc_sink.sv
// Purpose: sample sink standing in for the lane receiver
// Assumes: same clock as the checker, ready is a plain level
// Notes: hold_i stalls it; every taken word is queued with its cycle
`timescale 1ns/10ps
`default_nettype none
module slc_sink (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] sample_i,
  input wire logic valid_i,
  input wire logic hold_i,
  output logic ready_o
);
  logic [11:0] got[$];
  int stamp[$];
  int cyc;

  // ==========================================================
  // take side
  // one 12-bit word
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc <= 0;
      ready_o <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      ready_o <= !hold_i;
      if (valid_i && ready_o) begin
        got.push_back(sample_i);
        stamp.push_back(cyc);
      end
    end
  end
endmodule // slc_sink
`default_nettype wire

// ### tb/slc_link_check_test.sv
// Purpose: self-checking bench for the link checker
// Assumes: APB driven after rising edges, answers sampled at rising edges
// Notes: tables of settings; samples pass through a stalling sink
`include "slc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module slc_link_check_test;
  logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, hold;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, sample_valid_o, sample_ready_i;
  logic link_en_o, cfg_ok_o, er;
  logic [11:0] sample_o;
  logic [7:0] pll_range_o;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int done;

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  slc_link_check #(.FIFO_DEPTH(8)) dut_u (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sample_o(sample_o), .sample_valid_o(sample_valid_o),
    .sample_ready_i(sample_ready_i), .link_en_o(link_en_o),
    .cfg_ok_o(cfg_ok_o), .pll_range_o(pll_range_o));

  slc_sink sink_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .sample_i(sample_o), .valid_i(sample_valid_o), .hold_i(hold),
    .ready_o(sample_ready_i));

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the several hundred cycles used
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rdo, output logic ero);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {24'h00_0000, a};
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // request stands until the edge that sees pready high
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rdo = prdata_o;
    ero = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, rd, er);
  endtask

  function automatic logic [31:0] lw(input int l, m, f, k, s);
    return {11'h000, 4'(s), 6'(k), 4'(f), 4'(m), 3'(l)};
  endfunction

  // ok 2 leaves the verdict open at band edges; ebit 0 means none
  task automatic cfg(input logic [31:0] link, input int chip_decimation_ratio, fadc,
      input logic [7:0] pll, input int ok, ebit);
    wr(`SLC_OFS_LINK, link);
    wr(`SLC_OFS_DECIM, 32'(chip_decimation_ratio));
    wr(`SLC_OFS_ADCCLK, 32'(fadc));
    rdr(`SLC_OFS_STATUS);
    chk(32'(rd[15:8]), 32'(pll));
    chk(32'(pll_range_o), 32'(pll));
    if (ok < 2) chk(32'(cfg_ok_o), 32'(ok));
    if (ebit > 0) chk(32'(rd[ebit]), 32'h0000_0001);
    if (ok == 1) chk(32'(rd[4:1]), 32'h0000_0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 32'h0000_0000;
    pwdata_i = 32'h0000_0000;
    hold = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;

    rdr(`SLC_OFS_CTRL);
    chk(rd, 32'h0000_0000);
    rdr(`SLC_OFS_STATUS);
    chk(rd, 32'h0000_000E);
    chk(32'(cfg_ok_o), 32'h0000_0000);
    $display("test reset done");

    apb(1'b0, 8'h18, 32'h0000_0000, rd, er);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h02, 32'h0000_0001, rd, er);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    rdr(`SLC_OFS_DATA);
    chk(rd, 32'h0000_0000);
    $display("test unmapped done");

    cfg(lw(1, 2, 3, 4, 1), 3, 450, 8'h10, 1, 0);
    cfg(lw(1, 1, 3, 4, 2), 3, 675, 8'h10, 2, 0);
    cfg(lw(1, 2, 3, 4, 1), 3, 675, 8'h00, 2, 0);
    cfg(lw(1, 4, 6, 4, 1), 3, 450, 8'h00, 1, 0);
    cfg(lw(1, 4, 6, 4, 1), 3, 675, 8'h00, 2, 0);
    cfg(lw(1, 4, 6, 4, 1), 3, 750, 8'h30, 0, 0);
    cfg(lw(1, 4, 6, 4, 1), 3, 900, 8'h30, 0, 1);
    cfg(lw(1, 1, 3, 4, 2), 3, 300, 8'h50, 0, 1);
    cfg(lw(1, 1, 3, 6, 2), 3, 400, 8'h50, 0, 2);
    cfg(lw(3, 1, 1, 16, 2), 1, 400, 8'h50, 0, 2);
    cfg(lw(3, 1, 1, 20, 2), 1, 400, 8'h50, 1, 0);
    cfg(lw(3, 4, 2, 8, 1), 2, 400, 8'h10, 0, 2);
    cfg(lw(3, 4, 2, 12, 1), 2, 400, 8'h10, 1, 0);
    cfg(lw(3, 4, 4, 4, 2), 1, 400, 8'h00, 0, 2);
    cfg(lw(1, 1, 3, 4, 2), 2, 400, 8'h50, 0, 3);
    cfg(lw(1, 1, 3, 4, 1), 3, 400, 8'h50, 0, 4);
    $display("test settings done");

    // buffer fills against a stalled sink, then drains
    // software picks a supported row
    cfg(lw(1, 1, 3, 4, 2), 3, 400, 8'h50, 1, 0);
    @(posedge sys_clk_i);
    hold <= 1'b1;
    wr(`SLC_OFS_CTRL, 32'h0000_0001);
    // written bit shows only after the completing edge
    @(posedge sys_clk_i);
    chk(32'(link_en_o), 32'h0000_0001);
    done = 0;
    fork
      for (int i = 0; i < 12; i++) begin
        wr(`SLC_OFS_DATA, 32'hABCD_E000 | 32'(i * 273));
        done++;
      end
      begin
        repeat (150) @(posedge sys_clk_i);
        chk(32'(done >= 8 && done <= 9), 32'h0000_0001);
        hold <= 1'b0;
      end
    join
    repeat (100) @(posedge sys_clk_i);
    chk(32'(sink_u.got.size()), 32'h0000_000C);
    for (int i = 0; i < 12; i++) begin
      chk(32'(sink_u.got[i]), 32'(i * 273));
      if (i > 1) chk(32'(sink_u.stamp[i] - sink_u.stamp[i-1] >= 3), 1);
    end
    $display("test stream done");

    wr(`SLC_OFS_LINK, lw(1, 2, 3, 4, 1));
    rdr(`SLC_OFS_LINK);
    chk(rd, lw(1, 1, 3, 4, 2));
    rdr(`SLC_OFS_STATUS);
    chk(32'(rd[5]), 32'h0000_0001);
    wr(`SLC_OFS_STATUS, 32'h0000_0020);
    rdr(`SLC_OFS_STATUS);
    chk(32'(rd[5]), 32'h0000_0000);
    wr(`SLC_OFS_CTRL, 32'h0000_0000);
    @(posedge sys_clk_i);
    chk(32'(link_en_o), 32'h0000_0000);
    $display("test refused done");
    print_verdict();
  end
endmodule // slc_link_check_test
`default_nettype wire
